// [inc/imm_pkg.sv]
// Purpose: shared constants and types of the internal memory map
// Assumes: flat 32-bit address space, storage kept as 16-bit shorts
// Notes: region tables are indexed [view][region], view order 64/48/32/16
package imm_pkg;

  typedef enum logic [1:0] {IMM_K_RESV, IMM_K_PERIPH, IMM_K_ROM, IMM_K_RAM} imm_kind_t;
  typedef enum logic [1:0] {IMM_V64, IMM_V48, IMM_V32, IMM_V16} imm_view_t;

  localparam logic [31:0] IMM_PERIPH_TOP = 32'h0003_ffff;
  localparam logic [31:0] IMM_V64_TOP = 32'h0007_ffff;
  localparam logic [31:0] IMM_NRM_TOP = 32'h000f_ffff;
  localparam int IMM_PERIPH_AW = 18;

  // regions: blk0 rom, blk0 ram, blk1 rom, blk1 ram, blk2 ram, blk3 ram
  localparam int IMM_REGIONS = 6;
  localparam logic [31:0] IMM_LO [4][6] = '{
    '{32'h0004_0000, 32'h0004_c000, 32'h0005_0000, 32'h0005_c000, 32'h0006_0000, 32'h0007_0000},
    '{32'h0008_0000, 32'h0009_0000, 32'h000a_0000, 32'h000b_0000, 32'h000c_0000, 32'h000e_0000},
    '{32'h0008_0000, 32'h0009_8000, 32'h000a_0000, 32'h000b_8000, 32'h000c_0000, 32'h000e_0000},
    '{32'h0010_0000, 32'h0013_0000, 32'h0014_0000, 32'h0017_0000, 32'h0018_0000, 32'h001c_0000}};
  localparam logic [31:0] IMM_HI [4][6] = '{
    '{32'h0004_7fff, 32'h0004_ffff, 32'h0005_7fff, 32'h0005_ffff, 32'h0006_1fff, 32'h0007_1fff},
    '{32'h0008_aaa9, 32'h0009_5554, 32'h000a_aaa9, 32'h000b_5554, 32'h000c_2aa9, 32'h000e_2aa9},
    '{32'h0008_ffff, 32'h0009_ffff, 32'h000a_ffff, 32'h000b_ffff, 32'h000c_3fff, 32'h000e_3fff},
    '{32'h0011_ffff, 32'h0013_ffff, 32'h0015_ffff, 32'h0017_ffff, 32'h0018_7fff, 32'h001c_7fff}};
  localparam logic [1:0] IMM_REG_BLK [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
  localparam logic [5:0] IMM_REG_ROM = 6'h05;
  localparam logic [2:0] IMM_SHORTS [4] = '{3'h4, 3'h3, 3'h2, 3'h1};

  localparam int IMM_SRAM_BITS = 3 * 1024 * 1024;
  localparam int IMM_ROM_BITS = 4 * 1024 * 1024;
  // largest block holds a third of the sram; blocks 2 and 3 use the lower half
  localparam int IMM_BLK_SHORTS = IMM_SRAM_BITS / 3 / 16;
  localparam int IMM_MAX_W32 = IMM_SRAM_BITS / 32;
  localparam int IMM_MAX_W16 = IMM_SRAM_BITS / 16;
  localparam int IMM_MAX_W48 = IMM_SRAM_BITS / 48;

  localparam int IMM_DMA_SPI = 2;
  localparam int IMM_DMA_SERIAL = 12;
  localparam int IMM_DMA_INPUT = 8;
  localparam int IMM_DMA_CIPHER = 2;
  localparam int IMM_DMA_PARALLEL = 1;
  localparam logic [4:0] IMM_DMA_CHANNELS = 5'(IMM_DMA_SPI + IMM_DMA_SERIAL + IMM_DMA_INPUT
                                              + IMM_DMA_CIPHER + IMM_DMA_PARALLEL);

  localparam logic [63:0] IMM_UNDEF_DATA = 64'h0;
  localparam logic [15:0] IMM_ROM_FILL = 16'h0;
  localparam int IMM_CACHE_ENTRIES = 32;

endpackage

// [tb/imm_periph_model.sv]
// Purpose: peripheral register space standing behind the memory map
// Assumes: reads are answered combinationally while periph_req is high
// Notes: sixteen registers, aliased on the low address bits
`timescale 1ns/100ps
`default_nettype none
module imm_periph_model
  import imm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic periph_req,
  input wire logic periph_we,
  input wire logic [IMM_PERIPH_AW-1:0] periph_addr,
  input wire logic [31:0] periph_wdata,
  output logic [31:0] periph_rdata
);
  logic [31:0] regs [16];
  logic [31:0] last;
  // register space answer
  // an idle bus shows the inverse of its last value, so a stale read cannot pass
  always_comb periph_rdata = periph_req ? regs[periph_addr[3:0]] : ~last;
  always_ff @(posedge ref_clk)
  begin
    if (periph_req)
    begin
      last <= regs[periph_addr[3:0]];
      if (periph_we)
        regs[periph_addr[3:0]] <= periph_wdata;
    end
  end
endmodule // imm_periph_model
`default_nettype wire

// [tb/internal_memory_access_map_tb_top.sv]
// Purpose: self-checking bench of the internal memory map
// Assumes: answers arrive as the hand-over contract describes
// Notes: port arrays are indexed 0 data bus, 1 program bus, 2 dma
`timescale 1ns/100ps
`default_nettype none
module internal_memory_access_map_tb_top;
  import imm_pkg::*;
  localparam logic [31:0] RSV [15] = '{32'h0005_8000, 32'h0005_bfff, 32'h000b_0000,
    32'h000b_7fff, 32'h0016_0000, 32'h0016_ffff, 32'h0006_2000, 32'h000c_4000, 32'h0018_8000,
    32'h001b_ffff, 32'h0007_2000, 32'h000e_4000, 32'h001c_8000, 32'h0020_0000, 32'hffff_ffff};
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic simd = 1'b0;
  logic [3:0] wsel = 4'h0;
  logic [2:0] req = 3'h0;
  logic [2:0] we = 3'h0;
  logic [2:0][31:0] ad = '0;
  logic [2:0][63:0] wd = '0;
  logic [2:0] rdy, rv, rs;
  logic [2:0][63:0] rd;
  logic [4:0] ch = 5'h0;
  logic lst = 1'b0;
  logic done, if_ready, if_valid, if_hit, p_req, p_we;
  logic if_req = 1'b0;
  logic [31:0] if_addr = 32'h0;
  logic [47:0] if_data;
  logic [IMM_PERIPH_AW-1:0] p_addr, p_last;
  logic [31:0] p_wd, p_rd;
  int err_total = 0;
  int n_tests = 0;
  int n_per = 0;

  imm_core u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .second_element_enable(simd),
    .wide_view_sel(wsel), .dm_req(req[0]), .dm_we(we[0]), .dm_addr(ad[0]), .dm_wdata(wd[0]),
    .dm_ready(rdy[0]), .dm_rvalid(rv[0]), .dm_rdata(rd[0]), .dm_resv(rs[0]),
    .pm_req(req[1]), .pm_we(we[1]), .pm_addr(ad[1]), .pm_wdata(wd[1]), .pm_ready(rdy[1]),
    .pm_rvalid(rv[1]), .pm_rdata(rd[1]), .pm_resv(rs[1]), .iop_req(req[2]), .iop_we(we[2]),
    .iop_addr(ad[2]), .iop_wdata(wd[2]), .iop_chan(ch), .iop_last(lst), .iop_ready(rdy[2]),
    .iop_rvalid(rv[2]), .iop_rdata(rd[2]), .iop_resv(rs[2]), .iop_done(done),
    .if_req(if_req), .if_addr(if_addr), .if_ready(if_ready), .if_valid(if_valid),
    .if_data(if_data), .if_hit(if_hit), .periph_req(p_req), .periph_we(p_we),
    .periph_addr(p_addr), .periph_wdata(p_wd), .periph_rdata(p_rd));
  imm_periph_model u_periph (.ref_clk(ref_clk), .periph_req(p_req), .periph_we(p_we),
    .periph_addr(p_addr), .periph_wdata(p_wd), .periph_rdata(p_rd));

  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    if (p_req === 1'b1)
    begin
      n_per <= n_per + 1;
      p_last <= p_addr;
    end
  end

  task automatic give_verdict();
    if (err_total == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic to();
    err_total++;
    give_verdict();
  endtask

  // caller stands at a falling edge with address and data already set
  task automatic fire(input logic [2:0] m, output logic [2:0][63:0] g, output logic [2:0] s,
                      output logic dn);
    int i;
    logic [2:0] got;
    got = 3'h0;
    dn = 1'b0;
    g = '0;
    s = 3'h0;
    req = m;
    #1;
    i = 0;
    while ((rdy & m) !== m)
    begin
      i++;
      if (i > 8)
        to();
      @(negedge ref_clk);
    end
    @(posedge ref_clk);
    // answers stand one cycle only, so look at each of the next four falling edges
    for (i = 0; i < 4; i++)
    begin
      @(negedge ref_clk);
      if (i == 0)
        req = 3'h0;
      if (m[2] && done === 1'b1)
        dn = 1'b1;
      for (int p = 0; p < 3; p++)
      begin
        if (m[p] && rv[p] === 1'b1)
        begin
          got[p] = 1'b1;
          g[p] = rd[p];
          s[p] = rs[p];
        end
      end
    end
    chk("answer", 64'(m), 64'(got));
  endtask

  task automatic one(input int p, input logic w, input logic [31:0] a, input logic [63:0] d,
                     output logic [63:0] r, output logic s, output logic dn);
    logic [2:0][63:0] g;
    logic [2:0] ss;
    @(negedge ref_clk);
    we[p] = w;
    ad[p] = a;
    wd[p] = d;
    fire(3'(1 << p), g, ss, dn);
    r = g[p];
    s = ss[p];
  endtask

  task automatic fch(input logic [31:0] a, input logic col, output logic h,
                     output logic [47:0] q);
    int i;
    i = 0;
    @(negedge ref_clk);
    if_req = 1'b1;
    if_addr = a;
    if (col)
    begin
      we[1] = 1'b0;
      ad[1] = 32'h0005_c000;
      req[1] = 1'b1;
      #1;
      chk("fetch stall", 64'h0, 64'(if_ready));
      @(negedge ref_clk);
      req[1] = 1'b0;
    end
    #1;
    while (if_ready !== 1'b1)
    begin
      i++;
      if (i > 8)
        to();
      @(negedge ref_clk);
    end
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk("fetch answer", 64'h1, 64'(if_valid));
    h = if_hit;
    q = if_data;
    if_req = 1'b0;
  endtask

  initial
  begin
    logic [63:0] d, r;
    logic [2:0][63:0] g;
    logic [2:0] ss;
    logic s, dn, h;
    logic [47:0] q;
    logic [31:0] a, n;
    void'($urandom(89465));
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    // one long word seen through the other three views; n keeps the 48-bit index whole
    n = $urandom_range(5460, 0) * 3;
    d = {$urandom, $urandom};
    one(0, 1, 32'h0005_c000 + n, d, r, s, dn);
    for (int k = 0; k < 4; k++)
    begin
      one(1, 0, 32'h0017_0000 + 4 * n + k, 64'h0, r, s, dn);
      chk("short view", 64'(d[16*k+:16]), 64'(r[15:0]));
    end
    one(0, 0, 32'h000b_8000 + 2 * n, 64'h0, r, s, dn);
    chk("normal view", 64'(d[31:0]), 64'(r[31:0]));
    @(negedge ref_clk);
    wsel = 4'h2;
    one(0, 0, 32'h000b_0000 + 4 * n / 3, 64'h0, r, s, dn);
    chk("extended view", 64'(d[47:0]), 64'(r[47:0]));
    @(negedge ref_clk);
    wsel = 4'h0;
    foreach (RSV[i])
    begin
      one(i % 3, 1, RSV[i], {$urandom, $urandom}, r, s, dn);
      one(i % 3, 0, RSV[i], 64'h0, r, s, dn);
      chk("reserved flag", 64'h1, 64'(s));
      chk("reserved data", IMM_UNDEF_DATA, r);
    end
    one(0, 0, 32'h0005_c000 + n, 64'h0, r, s, dn);
    chk("kept word", d, r);
    a = 32'h0004_0000 + $urandom_range(32'h7fff, 0);
    one(1, 1, a, {$urandom, $urandom}, r, s, dn);
    one(1, 0, a, 64'h0, r, s, dn);
    chk("rom data", {4{IMM_ROM_FILL}}, r);
    chk("rom flag", 64'h0, 64'(s));
    for (int v = 2; v < 4; v++)
    begin
      for (int j = 1; j < 6; j++)
      begin
        if (j != 2)
        begin
          one(0, 0, IMM_HI[v][j], 64'h0, r, s, dn);
          chk("top flag", 64'h0, 64'(s));
        end
      end
    end
    a = {14'h0, 18'($urandom)};
    d = {32'h0, $urandom};
    one(0, 1, a, d, r, s, dn);
    one(0, 0, a, 64'h0, r, s, dn);
    chk("periph data", d, r);
    chk("periph addr", 64'(a[17:0]), 64'(p_last));
    chk("periph count", 64'h2, 64'(n_per));
    for (int t = 0; t < 4; t++)
    begin
      @(negedge ref_clk);
      ch = (t == 0) ? 5'd24 : 5'($urandom_range(23, 0));
      lst = 1'b1;
      we = 3'h7;
      ad[0] = 32'h0004_c000 + $urandom_range(32'h3fff, 0);
      ad[1] = 32'h0005_c000 + $urandom_range(32'h3fff, 0);
      ad[2] = 32'h0006_0000 + $urandom_range(32'h1fff, 0);
      for (int p = 0; p < 3; p++)
        wd[p] = {$urandom, $urandom};
      fire(3'h7, g, ss, dn);
      chk("dma done", 64'h1, 64'(dn));
      @(negedge ref_clk);
      we = 3'h0;
      fire(3'h7, g, ss, dn);
      for (int p = 0; p < 3; p++)
        chk("parallel read", wd[p], g[p]);
    end
    @(negedge ref_clk);
    ch = 5'd25;
    one(2, 1, 32'h0006_0000, 64'h5, r, s, dn);
    chk("bad channel flag", 64'h1, 64'(s));
    chk("bad channel done", 64'h0, 64'(dn));
    @(negedge ref_clk);
    lst = 1'b0;
    ad[0] = 32'h0004_c000;
    ad[1] = 32'h0004_c001;
    req = 3'h3;
    #1;
    chk("shared block", 64'h2, 64'({rdy[0], rdy[1]}));
    @(negedge ref_clk);
    req = 3'h0;
    a = 32'h0009_0000 + $urandom_range(32'h5554, 0);
    d = {$urandom, $urandom};
    @(negedge ref_clk);
    wsel = 4'h1;
    one(0, 1, a, d, r, s, dn);
    @(negedge ref_clk);
    wsel = 4'h0;
    fch(a, 1'b1, h, q);
    chk("collided fetch", 64'h0, 64'(h));
    chk("fetch data", 64'(d[47:0]), 64'(q));
    fch(a, 1'b0, h, q);
    chk("cached fetch", 64'h1, 64'(h));
    chk("cached data", 64'(d[47:0]), 64'(q));
    fch(a ^ 32'h1, 1'b0, h, q);
    fch(a ^ 32'h1, 1'b0, h, q);
    chk("plain fetch", 64'h0, 64'(h));
    a = 32'h0009_8000 + $urandom_range(32'h7ffe, 0);
    d = {$urandom, $urandom};
    @(negedge ref_clk);
    simd = 1'b1;
    one(0, 1, a, d, r, s, dn);
    @(negedge ref_clk);
    simd = 1'b0;
    one(0, 0, a + 1, 64'h0, r, s, dn);
    chk("pair high", 64'(d[63:32]), 64'(r[31:0]));
    one(0, 1, a, {$urandom, $urandom}, r, s, dn);
    one(0, 0, a + 1, 64'h0, r, s, dn);
    chk("single write", 64'(d[63:32]), 64'(r[31:0]));
    // write then read the same normal word on consecutive edges
    @(negedge ref_clk);
    we[0] = 1'b1;
    ad[0] = a;
    wd[0] = {$urandom, $urandom};
    req[0] = 1'b1;
    @(negedge ref_clk);
    we[0] = 1'b0;
    @(negedge ref_clk);
    req[0] = 1'b0;
    chk("back to back", 64'(wd[0][31:0]), 64'(rd[0][31:0]));
    give_verdict();
  end
endmodule // internal_memory_access_map_tb_top
`default_nettype wire

// [verilog/imm_core.sv]
// Purpose: internal memory system: address decode, four word views, three access ports,
//   selective instruction cache
// Assumes: all inputs synchronous to ref_clk; the dma engine sequences its own chains
// Notes: rom contents read as a fixed fill value
//
// Overview of operation
// - Lowest range decodes to peripheral registers
// - 64-bit hole after block 1 rom reserved
// - 32-bit hole after block 1 rom reserved
// - 16-bit hole after block 1 rom reserved
// - Remainder of block 2 windows reserved
// - Block 3 remainder and top space reserved
// - Three megabit sram, four megabit rom
// - Sram word capacity per width
// - Every location reachable in four widths
// - Core and dma access blocks independently
// - Two core plus one dma transfer
// - Single cycle needs separate blocks, cached fetch
// - Cache only fetches colliding with pm data
// - Four operands plus cached instruction per cycle
// - Secondary element only when enable set
// - Enabled secondary element doubles core 32- and 16-bit transfers
// - Twenty-five dma channels in total
// - Completion event on the last dma transfer of a chain, chaining
// - Dma runs without stalling the core
`timescale 1ns/100ps
`default_nettype none

module imm_core
  import imm_pkg::*;
#(
  parameter int CACHE_N = IMM_CACHE_ENTRIES
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic second_element_enable,
  input wire logic [3:0] wide_view_sel,
  input wire logic dm_req,
  input wire logic dm_we,
  input wire logic [31:0] dm_addr,
  input wire logic [63:0] dm_wdata,
  output logic dm_ready,
  output logic dm_rvalid,
  output logic [63:0] dm_rdata,
  output logic dm_resv,
  input wire logic pm_req,
  input wire logic pm_we,
  input wire logic [31:0] pm_addr,
  input wire logic [63:0] pm_wdata,
  output logic pm_ready,
  output logic pm_rvalid,
  output logic [63:0] pm_rdata,
  output logic pm_resv,
  input wire logic iop_req,
  input wire logic iop_we,
  input wire logic [31:0] iop_addr,
  input wire logic [63:0] iop_wdata,
  input wire logic [4:0] iop_chan,
  input wire logic iop_last,
  output logic iop_ready,
  output logic iop_rvalid,
  output logic [63:0] iop_rdata,
  output logic iop_resv,
  output logic iop_done,
  input wire logic if_req,
  input wire logic [31:0] if_addr,
  output logic if_ready,
  output logic if_valid,
  output logic [47:0] if_data,
  output logic if_hit,
  output logic periph_req,
  output logic periph_we,
  output logic [IMM_PERIPH_AW-1:0] periph_addr,
  output logic [31:0] periph_wdata,
  input wire logic [31:0] periph_rdata
);

  localparam int CB = $clog2(CACHE_N);

  typedef struct packed {
    imm_kind_t kind;
    imm_view_t view;
    logic [1:0] blk;
    logic [16:0] idx;
  } imm_dec_t;

  typedef struct packed {
    logic [2:0] rvalid;
    logic [2:0] resv;
    logic [2:0][63:0] rdata;
    logic [2:0] pwait;
    logic iop_done;
    logic periph_req;
    logic periph_we;
    logic [IMM_PERIPH_AW-1:0] periph_addr;
    logic [31:0] periph_wdata;
    logic if_valid;
    logic if_hit;
    logic [47:0] if_data;
    logic pend_v;
    logic [31:0] pend_a;
    logic [CACHE_N-1:0] cvalid;
    logic [CACHE_N-1:0][31:0] ctag;
    logic [CACHE_N-1:0][47:0] cdata;
  } imm_state_t;

  function automatic imm_dec_t imm_decode(input logic [31:0] a, input logic [3:0] wsel);
    imm_dec_t d;
    imm_view_t v;
    logic [31:0] off;
    d = '{kind: IMM_K_RESV, view: IMM_V16, blk: 2'h0, idx: 17'h0};
    v = IMM_V16;
    off = 32'h0;
    if (a <= IMM_PERIPH_TOP)
    begin
      d.kind = IMM_K_PERIPH;
    end
    else
    begin
      // 48 and 32 bit views share one window per block, chosen by wide_view_sel
      if (a <= IMM_V64_TOP)
        v = IMM_V64;
      else if (a <= IMM_NRM_TOP)
        v = wsel[a[18:17]] ? IMM_V48 : IMM_V32;
      d.view = v;
      // remainders and top space match no region
      for (int r = 0; r < IMM_REGIONS; r++)
      begin
        if (a >= IMM_LO[int'(v)][r] && a <= IMM_HI[int'(v)][r])
        begin
          off = a - IMM_LO[int'(v)][r];
          d.kind = IMM_REG_ROM[r] ? IMM_K_ROM : IMM_K_RAM;
          d.blk = IMM_REG_BLK[r];
          // each view scales into the same short storage
          d.idx = 17'(off * 32'(IMM_SHORTS[int'(v)]));
        end
      end
    end
    return d;
  endfunction

  function automatic logic [2:0] imm_count(input imm_dec_t d, input logic simd);
    logic [2:0] c;
    c = IMM_SHORTS[int'(d.view)];
    // paired values for the secondary element
    if (simd && (d.view == IMM_V32 || d.view == IMM_V16))
      c = 3'(c * 3'h2);
    return c;
  endfunction

  function automatic logic is_mem(input imm_dec_t d);
    return d.kind == IMM_K_ROM || d.kind == IMM_K_RAM;
  endfunction

  // sram blocks as short arrays; rom is not stored
  // capacity set by IMM_SRAM_BITS across all widths
  logic [15:0] mem [4][IMM_BLK_SHORTS];

  imm_state_t st_r;
  imm_state_t st_nxt;

  logic req [3];
  logic we [3];
  logic [31:0] addr [3];
  logic [63:0] wdat [3];
  imm_dec_t dec [4];
  logic [2:0] cnt [4];
  logic [63:0] rd [4];
  logic [2:0] per;
  logic [2:0] rdy;
  logic [2:0] fire;
  logic [2:0] wr_en;
  logic chan_ok;
  logic blkclash;
  logic [CB-1:0] ci;
  logic hit;
  logic fill;

  assign req[0] = dm_req;
  assign req[1] = pm_req;
  assign req[2] = iop_req;
  assign we[0] = dm_we;
  assign we[1] = pm_we;
  assign we[2] = iop_we;
  assign addr[0] = dm_addr;
  assign addr[1] = pm_addr;
  assign addr[2] = iop_addr;
  assign wdat[0] = dm_wdata;
  assign wdat[1] = pm_wdata;
  assign wdat[2] = iop_wdata;

  // channel numbers beyond the budget are refused
  assign chan_ok = iop_chan < IMM_DMA_CHANNELS;

  always_comb
  begin
    for (int p = 0; p < 3; p++)
    begin
      dec[p] = imm_decode(addr[p], wide_view_sel);
      // only core buses see the secondary element
      cnt[p] = imm_count(dec[p], second_element_enable && p != 2);
      per[p] = req[p] && dec[p].kind == IMM_K_PERIPH;
    end
    // fetches in the 48/32-bit window always use the 48-bit view, whatever the data views are set to
    dec[3] = imm_decode(if_addr, 4'hf);
    cnt[3] = IMM_SHORTS[int'(IMM_V48)];
  end

  // pm data stalls when dm owns the same block
  assign blkclash = req[0] && req[1] && is_mem(dec[0]) && is_mem(dec[1])
                    && dec[0].blk == dec[1].blk;

  // one peripheral slot per cycle, dm first, then pm, then dma
  // dma waits only on its own peripheral answer or slot
  // core traffic to memory never holds dma back
  assign rdy[0] = !st_r.pwait[0];
  assign rdy[1] = !st_r.pwait[1] && !(per[1] && per[0]) && !blkclash;
  assign rdy[2] = !st_r.pwait[2] && !(per[2] && (per[0] || per[1]));
  assign fire = {req[2] && rdy[2], req[1] && rdy[1], req[0] && rdy[0]};

  always_comb
  begin
    for (int p = 0; p < 3; p++)
      wr_en[p] = fire[p] && we[p] && dec[p].kind == IMM_K_RAM && (p != 2 || chan_ok);
  end

  always_comb
  begin
    for (int p = 0; p < 4; p++)
    begin
      rd[p] = IMM_UNDEF_DATA;
      for (int k = 0; k < 4; k++)
      begin
        if (is_mem(dec[p]) && k < int'(cnt[p]))
          rd[p][16*k +: 16] = (dec[p].kind == IMM_K_RAM)
                              ? mem[dec[p].blk][16'(dec[p].idx + 17'(k))] : IMM_ROM_FILL;
      end
    end
  end

  // three write ports per cycle; dma wins a same-short collision with the core
  always_ff @(posedge ref_clk)
  begin
    for (int p = 0; p < 3; p++)
    begin
      for (int k = 0; k < 4; k++)
      begin
        if (wr_en[p] && k < int'(cnt[p]))
          mem[dec[p].blk][16'(dec[p].idx + 17'(k))] <= wdat[p][16*k +: 16];
      end
    end
  end

  assign ci = if_addr[CB-1:0];
  assign hit = st_r.cvalid[ci] && st_r.ctag[ci] == if_addr;
  // a cached fetch proceeds beside both data buses
  assign if_ready = hit || !req[1];
  assign fill = if_req && if_ready && !hit && st_r.pend_v && st_r.pend_a == if_addr;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rvalid = 3'h0;
    st_nxt.iop_done = 1'b0;
    st_nxt.periph_req = 1'b0;
    st_nxt.if_valid = 1'b0;
    for (int p = 0; p < 3; p++)
    begin
      if (st_r.pwait[p])
      begin
        st_nxt.rvalid[p] = 1'b1;
        st_nxt.resv[p] = 1'b0;
        st_nxt.rdata[p] = {32'h0, periph_rdata};
        st_nxt.pwait[p] = 1'b0;
      end
      if (fire[p])
      begin
        // a dma access on a bad channel never reaches the register space
        if (dec[p].kind == IMM_K_PERIPH && (p != 2 || chan_ok))
        begin
          // forwarded to the register space a cycle later
          st_nxt.periph_req = 1'b1;
          st_nxt.periph_we = we[p];
          st_nxt.periph_addr = addr[p][IMM_PERIPH_AW-1:0];
          st_nxt.periph_wdata = wdat[p][31:0];
          st_nxt.pwait[p] = 1'b1;
        end
        else if (dec[p].kind == IMM_K_RESV || (p == 2 && !chan_ok))
        begin
          // reserved answers with the undefined pattern
          st_nxt.rvalid[p] = 1'b1;
          st_nxt.resv[p] = 1'b1;
          st_nxt.rdata[p] = IMM_UNDEF_DATA;
        end
        else
        begin
          st_nxt.rvalid[p] = 1'b1;
          st_nxt.resv[p] = 1'b0;
          st_nxt.rdata[p] = we[p] ? st_r.rdata[p] : rd[p];
        end
      end
    end
    // completion pulse closes the last transfer of a chain, flagged by iop_last
    st_nxt.iop_done = fire[2] && iop_last && chan_ok;
    if (if_req && if_ready)
    begin
      st_nxt.if_valid = 1'b1;
      st_nxt.if_hit = hit;
      st_nxt.if_data = hit ? st_r.cdata[ci] : rd[3][47:0];
    end
    // only a fetch that lost to pm data is cached
    if (fill)
    begin
      st_nxt.cvalid[ci] = 1'b1;
      st_nxt.ctag[ci] = if_addr;
      st_nxt.cdata[ci] = rd[3][47:0];
      st_nxt.pend_v = 1'b0;
    end
    // a new collision overrides a fill in the same cycle
    if (if_req && !hit && req[1])
    begin
      st_nxt.pend_v = 1'b1;
      st_nxt.pend_a = if_addr;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign dm_ready = rdy[0];
  assign pm_ready = rdy[1];
  assign iop_ready = rdy[2];
  assign dm_rvalid = st_r.rvalid[0];
  assign pm_rvalid = st_r.rvalid[1];
  assign iop_rvalid = st_r.rvalid[2];
  assign dm_rdata = st_r.rdata[0];
  assign pm_rdata = st_r.rdata[1];
  assign iop_rdata = st_r.rdata[2];
  assign dm_resv = st_r.resv[0];
  assign pm_resv = st_r.resv[1];
  assign iop_resv = st_r.resv[2];
  assign iop_done = st_r.iop_done;
  assign if_valid = st_r.if_valid;
  assign if_data = st_r.if_data;
  assign if_hit = st_r.if_hit;
  assign periph_req = st_r.periph_req;
  assign periph_we = st_r.periph_we;
  assign periph_addr = st_r.periph_addr;
  assign periph_wdata = st_r.periph_wdata;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_dm_periph;
    fire[0] && dec[0].kind == IMM_K_PERIPH;
  endsequence
  sequence s_forward;
    periph_req && periph_addr == $past(dm_addr[IMM_PERIPH_AW-1:0]);
  endsequence
  sequence s_dm_wr32;
    fire[0] && dm_we && dec[0].kind == IMM_K_RAM && dec[0].view == IMM_V32
      && !second_element_enable && !wr_en[1] && !wr_en[2];
  endsequence
  sequence s_dm_rd_same;
    fire[0] && !dm_we && dm_addr == $past(dm_addr) && !second_element_enable;
  endsequence
  sequence s_conflict;
    if_req && !hit && pm_req;
  endsequence

  AST_PERIPH_FWD: assert property (s_dm_periph |=> s_forward ##1 dm_rvalid && !dm_resv)
    else $error("peripheral access not forwarded");
  AST_RESV_ANSWER: assert property ((fire[1] && dec[1].kind == IMM_K_RESV)
      |=> pm_rvalid && pm_resv && pm_rdata == IMM_UNDEF_DATA)
    else $error("reserved read not answered as undefined");
  AST_RAM_STORE: assert property (s_dm_wr32 ##1 s_dm_rd_same
      |=> dm_rdata[31:0] == $past(dm_wdata[31:0], 2))
    else $error("stored word not read back");
  AST_IOP_FREE: assert property ((iop_req && is_mem(dec[2]) && !st_r.pwait[2])
      |-> iop_ready ##1 iop_rvalid)
    else $error("dma access to memory stalled");
  AST_THREE_XFER: assert property ((&fire && is_mem(dec[0]) && is_mem(dec[1]) && is_mem(dec[2])
      && chan_ok) |=> dm_rvalid && pm_rvalid && iop_rvalid)
    else $error("three transfers not completed together");
  AST_BLOCK_CLASH: assert property ((blkclash && !st_r.pwait[0])
      |-> !pm_ready ##0 (dm_ready [*1]) ##1 dm_rvalid)
    else $error("same block access not serialised");
  AST_FILL_ONLY_CONFLICT: assert property ($changed(st_r.cvalid) |-> $past(st_r.pend_v))
    else $error("cache filled without a prior collision");
  AST_CONFLICT_PEND: assert property (s_conflict |-> !if_ready ##1 st_r.pend_v)
    else $error("colliding fetch not marked for caching");
  AST_FETCH_HIT: assert property ((if_req && hit && dm_req && pm_req)
      |-> if_ready ##1 if_valid && if_hit)
    else $error("cached fetch did not proceed");
  AST_SIMD_OFF: assert property ((fire[0] && !dm_we && dec[0].view == IMM_V32
      && !second_element_enable) |=> dm_rdata[63:32] == 32'h0)
    else $error("secondary data returned while disabled");
  AST_SIMD_PAIR: assert property ((fire[1] && second_element_enable && dec[1].view == IMM_V16)
      |-> cnt[1] == 3'h2)
    else $error("paired transfer width wrong");
  AST_CHAN_LIMIT: assert property ((fire[2] && iop_chan >= IMM_DMA_CHANNELS)
      |=> iop_rvalid && iop_resv && !iop_done)
    else $error("out of range channel accepted");
  AST_DMA_DONE: assert property ((fire[2] && iop_last && chan_ok)
      |=> iop_done ##1 (!iop_done || $past(fire[2] && iop_last && chan_ok)))
    else $error("dma completion pulse missing");
  AST_CORE_NOT_STALLED: assert property ((dm_req && !per[0] && !st_r.pwait[0]) |-> dm_ready)
    else $error("core held back by dma");

endmodule // imm_core

`default_nettype wire
